// ==== src/bridge_regs_pkg.sv ====
// constants shared by the bus number and i/o window register block
// assumes apb byte addressing with one aligned 32-bit word per register
package bridge_regs_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] bus_num_offset = 8'h18;
  localparam logic [7:0] io_window_offset = 8'h1c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int primary_lsb = 0;
  localparam int secondary_lsb = 8;
  localparam int subordinate_lsb = 16;
  localparam int latency_lsb = 24;
  localparam int io_base_ind_lsb = 0;
  localparam int io_base_addr_lsb = 4;
  localparam int io_limit_ind_lsb = 8;
  localparam int io_limit_addr_lsb = 12;

  // ****************************************
  // reset and fixed values
  // ****************************************
  localparam logic [7:0] bus_num_reset = 8'h00;
  localparam logic [7:0] latency_reset = 8'h00;
  localparam logic [3:0] io_addr_reset = 4'h0;
  localparam logic [3:0] io_32bit_indicator = 4'h1;
  localparam logic [11:0] io_base_low_fill = 12'h000;
  localparam logic [11:0] io_limit_low_fill = 12'hfff;

  typedef enum logic [1:0] {
    mst_idle,
    mst_addr,
    mst_data,
    mst_stop
  } mst_state_t;

endpackage

// ==== src/io_window_match.sv ====
// i/o address window comparator
// assumes base and limit already assembled into full 32-bit bounds
`timescale 1ns/1ps
module io_window_match #(
  parameter int addr_width = 32
) (
  input wire logic [addr_width-1:0] io_addr,
  input wire logic [addr_width-1:0] base_addr,
  input wire logic [addr_width-1:0] limit_addr,
  output logic in_window
);

  // inclusive bounds check
  assign in_window = (io_addr >= base_addr) && (io_addr <= limit_addr);

endmodule

// ==== src/latency_expiry.sv ====
// secondary master latency timer counter
// assumes frame_start pulses one cycle when the secondary frame is asserted
`timescale 1ns/1ps
module latency_expiry #(
  parameter int count_width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_start,
  input wire logic mastering,
  input wire logic [count_width-1:0] timer_load,
  output logic expired
);

  logic [count_width-1:0] count_reg;
  logic running_reg;

  // ****************************************
  // down counter from frame assertion
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      running_reg <= 1'b0;
    end else if (frame_start) begin
      count_reg <= timer_load;
      running_reg <= 1'b1;
    end else if (!mastering) begin
      running_reg <= 1'b0;
    end else if (running_reg && count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign expired = running_reg && (count_reg == '0);

endmodule

// ==== src/bridge_bus_number_io_window_regs.sv ====
// apb register block for bus numbers, secondary latency timer and i/o window
// assumes an apb master on pclk; upper 16 bits of the i/o window come in as ports
//
// Behaviour
// - primary bus number is an 8-bit read/write field at bits 7:0 of 18h, reset to zero.
// - secondary bus number is an 8-bit read/write field at bits 15:8 of 18h, reset to zero.
// - subordinate bus number is an 8-bit read/write field at bits 23:16 of 18h, reset to zero.
// - secondary latency timer at bits 31:24 of 18h, reset to zero, counts clocks from secondary frame.
// - with timer zero and grant removed the master ends after the first data phase, except mwi.
// - indicator fields at 1ch bits 3:0 and 11:8 read one for 32-bit i/o decoding.
// - bits 7:4 of 1ch hold base address bits 15:12, reset zero, low bits taken as zeros.
// - bits 15:12 of 1ch hold limit address bits 15:12, reset zero, low bits taken as ones.
// - address bits 31:16 of base and limit come from separate upper registers outside.
`timescale 1ns/1ps
module bridge_bus_number_io_window_regs #(
  parameter int addr_width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  input wire logic [31:0] io_addr,
  output logic io_forward,
  input wire logic sec_frame_start,
  input wire logic sec_mastering,
  input wire logic sec_grant,
  input wire logic sec_data_phase_done,
  input wire logic sec_mwi,
  output logic sec_latency_expired,
  output logic sec_master_stop,
  output logic [7:0] primary_bus_num,
  output logic [7:0] secondary_bus_num,
  output logic [7:0] subordinate_bus_num
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] primary_bus_num_reg;
  logic [7:0] secondary_bus_num_reg;
  logic [7:0] subordinate_bus_num_reg;
  logic [7:0] downstream_latency_timer_reg;
  logic [3:0] io_base_addr_reg;
  logic [3:0] io_limit_addr_reg;
  logic [31:0] rdata_next;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic hit_bus;
  logic hit_io;
  logic wr_access;
  logic rd_setup;
  logic [31:0] io_base_full;
  logic [31:0] io_limit_full;
  logic expired;
  bridge_regs_pkg::mst_state_t mst_state_reg;
  logic setup_phase;
  logic access_phase;
  logic unmapped;
  logic wr_bus;
  logic wr_io;
  logic wr_primary;
  logic wr_secondary;
  logic wr_subordinate;
  logic wr_latency;
  logic wr_io_base;
  logic wr_io_limit;
  logic [31:0] bus_word;
  logic [31:0] io_word;
  logic stop_allowed;
  logic past_first_phase;

  // ****************************************
  // address decode
  // ****************************************
  always_comb begin
    hit_bus = 1'b0;
    hit_io = 1'b0;
    if (paddr == addr_width'(bridge_regs_pkg::bus_num_offset)) begin
      hit_bus = 1'b1;
    end else if (paddr == addr_width'(bridge_regs_pkg::io_window_offset)) begin
      hit_io = 1'b1;
    end
  end

  assign unmapped = !(hit_bus || hit_io);

  // ****************************************
  // apb phases
  // ****************************************
  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access = access_phase && pwrite;
  assign rd_setup = setup_phase && !pwrite;
  // zero wait states: every access phase completes at once
  assign pready = 1'b1;

  // ****************************************
  // field write enables
  // ****************************************
  assign wr_bus = wr_access && hit_bus;
  assign wr_io = wr_access && hit_io;
  assign wr_primary = wr_bus && pstrb[0];
  assign wr_secondary = wr_bus && pstrb[1];
  assign wr_subordinate = wr_bus && pstrb[2];
  assign wr_latency = wr_bus && pstrb[3];
  assign wr_io_base = wr_io && pstrb[0];
  assign wr_io_limit = wr_io && pstrb[1];

  // ****************************************
  // primary bus number
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_bus_num_reg <= bridge_regs_pkg::bus_num_reset;
    end else if (wr_primary) begin
      primary_bus_num_reg <= pwdata[bridge_regs_pkg::primary_lsb +: 8];
    end
  end

  // ****************************************
  // secondary bus number
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      secondary_bus_num_reg <= bridge_regs_pkg::bus_num_reset;
    end else if (wr_secondary) begin
      secondary_bus_num_reg <= pwdata[bridge_regs_pkg::secondary_lsb +: 8];
    end
  end

  // ****************************************
  // subordinate bus number
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subordinate_bus_num_reg <= bridge_regs_pkg::bus_num_reset;
    end else if (wr_subordinate) begin
      subordinate_bus_num_reg <= pwdata[bridge_regs_pkg::subordinate_lsb +: 8];
    end
  end

  // ****************************************
  // secondary latency timer value
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      downstream_latency_timer_reg <= bridge_regs_pkg::latency_reset;
    end else if (wr_latency) begin
      downstream_latency_timer_reg <= pwdata[bridge_regs_pkg::latency_lsb +: 8];
    end
  end

  // ****************************************
  // i/o window base nibble
  // ****************************************
  // indicator nibbles have no storage, so writes there fall away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_base_addr_reg <= bridge_regs_pkg::io_addr_reset;
    end else if (wr_io_base) begin
      io_base_addr_reg <= pwdata[bridge_regs_pkg::io_base_addr_lsb +: 4];
    end
  end

  // ****************************************
  // i/o window limit nibble
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_limit_addr_reg <= bridge_regs_pkg::io_addr_reset;
    end else if (wr_io_limit) begin
      io_limit_addr_reg <= pwdata[bridge_regs_pkg::io_limit_addr_lsb +: 4];
    end
  end

  // ****************************************
  // read data
  // ****************************************
  assign bus_word = {downstream_latency_timer_reg, subordinate_bus_num_reg,
                     secondary_bus_num_reg, primary_bus_num_reg};

  always_comb begin
    io_word = 32'h0000_0000;
    io_word[bridge_regs_pkg::io_base_ind_lsb +: 4] = bridge_regs_pkg::io_32bit_indicator;
    io_word[bridge_regs_pkg::io_base_addr_lsb +: 4] = io_base_addr_reg;
    io_word[bridge_regs_pkg::io_limit_ind_lsb +: 4] = bridge_regs_pkg::io_32bit_indicator;
    io_word[bridge_regs_pkg::io_limit_addr_lsb +: 4] = io_limit_addr_reg;
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_bus) begin
      rdata_next = bus_word;
    end else if (hit_io) begin
      rdata_next = io_word;
    end
  end

  // read data captured in the setup cycle, zero for writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata_reg <= rd_setup ? rdata_next : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= unmapped;
    end
  end

  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && access_phase;

  // ****************************************
  // i/o window forwarding
  // ****************************************
  assign io_base_full = {io_base_upper, io_base_addr_reg, bridge_regs_pkg::io_base_low_fill};
  assign io_limit_full = {io_limit_upper, io_limit_addr_reg, bridge_regs_pkg::io_limit_low_fill};

  io_window_match #(
    .addr_width(32)
  ) u_io_match (
    .io_addr(io_addr),
    .base_addr(io_base_full),
    .limit_addr(io_limit_full),
    .in_window(io_forward)
  );

  // ****************************************
  // secondary latency timer
  // ****************************************
  latency_expiry #(
    .count_width(8)
  ) u_latency (
    .pclk(pclk),
    .presetn(presetn),
    .frame_start(sec_frame_start),
    .mastering(sec_mastering),
    .timer_load(downstream_latency_timer_reg),
    .expired(expired)
  );

  assign sec_latency_expired = expired;

  // tracks secondary master burst to raise the stop request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mst_state_reg <= bridge_regs_pkg::mst_idle;
    end else begin
      case (mst_state_reg)
        bridge_regs_pkg::mst_idle: begin
          if (sec_frame_start) begin
            mst_state_reg <= bridge_regs_pkg::mst_addr;
          end
        end
        bridge_regs_pkg::mst_addr: begin
          if (!sec_mastering) begin
            mst_state_reg <= bridge_regs_pkg::mst_idle;
          end else if (sec_data_phase_done) begin
            mst_state_reg <= bridge_regs_pkg::mst_data;
          end
        end
        bridge_regs_pkg::mst_data: begin
          if (!sec_mastering) begin
            mst_state_reg <= bridge_regs_pkg::mst_idle;
          end else if (sec_master_stop) begin
            mst_state_reg <= bridge_regs_pkg::mst_stop;
          end
        end
        default: begin
          if (!sec_mastering) begin
            mst_state_reg <= bridge_regs_pkg::mst_idle;
          end
        end
      endcase
    end
  end

  // zero timer: stop after first data phase once grant is gone, mwi exempt
  assign stop_allowed = !sec_grant && !sec_mwi;
  assign past_first_phase = (mst_state_reg == bridge_regs_pkg::mst_data) ||
                            (mst_state_reg == bridge_regs_pkg::mst_stop);

  always_comb begin
    sec_master_stop = 1'b0;
    if (past_first_phase) begin
      if (downstream_latency_timer_reg == bridge_regs_pkg::latency_reset) begin
        sec_master_stop = stop_allowed;
      end else begin
        sec_master_stop = expired && stop_allowed;
      end
    end
  end

  assign primary_bus_num = primary_bus_num_reg;
  assign secondary_bus_num = secondary_bus_num_reg;
  assign subordinate_bus_num = subordinate_bus_num_reg;

endmodule

// ==== test/bridge_regs_sva.sv ====
// checker for the bus number and i/o window register block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
module bridge_regs_chk #(
  parameter int addr_width = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [addr_width-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] io_base_upper,
  input wire logic [15:0] io_limit_upper,
  input wire logic [31:0] io_addr,
  input wire logic io_forward,
  input wire logic sec_grant,
  input wire logic sec_mwi,
  input wire logic sec_master_stop,
  input wire logic [7:0] primary_bus_num,
  input wire logic [7:0] secondary_bus_num,
  input wire logic [7:0] subordinate_bus_num
);
  // ****************************************
  // shadow of the window nibbles
  // ****************************************
  logic [3:0] base_reg;
  logic [3:0] limit_reg;
  wire logic wr_bus = psel & penable & pwrite & (paddr == 8'h18);
  wire logic wr_io = psel & penable & pwrite & (paddr == 8'h1c);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_reg <= 4'h0;
      limit_reg <= 4'h0;
    end else if (wr_io) begin
      if (pstrb[0]) base_reg <= pwdata[7:4];
      if (pstrb[1]) limit_reg <= pwdata[15:12];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_read(logic [7:0] a);
    psel && !penable && !pwrite && paddr == a ##1 psel && penable;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  a_pri_write: assert property (wr_bus && pstrb[0] |=> primary_bus_num == $past(pwdata[7:0]))
    else $error("primary bus number not written");
  a_sec_write: assert property (wr_bus && pstrb[1] |=> secondary_bus_num == $past(pwdata[15:8]))
    else $error("secondary bus number not written");
  a_sub_write: assert property (wr_bus && pstrb[2] |=> subordinate_bus_num == $past(pwdata[23:16]))
    else $error("subordinate bus number not written");
  a_pri_hold: assert property (!(wr_bus && pstrb[0]) |=> $stable(primary_bus_num))
    else $error("primary bus number changed without write");
  a_bus_read: assert property (s_read(8'h18) |->
    prdata[23:0] == {subordinate_bus_num, secondary_bus_num, primary_bus_num})
    else $error("bus number readback wrong");
  a_io_read: assert property (s_read(8'h1c) |-> prdata == {16'h0000, limit_reg, 4'h1, base_reg, 4'h1})
    else $error("io window readback wrong");
  a_io_window: assert property (io_forward ==
    (io_addr >= {io_base_upper, base_reg, 12'h000} && io_addr <= {io_limit_upper, limit_reg, 12'hfff}))
    else $error("io forward decision wrong");
  a_stop_cause: assert property (sec_master_stop |-> !sec_grant && !sec_mwi)
    else $error("master stop while granted or mwi");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
endmodule
bind bridge_bus_number_io_window_regs bridge_regs_chk #(.addr_width(addr_width)) i_bridge_regs_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .io_base_upper(io_base_upper), .io_limit_upper(io_limit_upper), .io_addr(io_addr), .io_forward(io_forward),
  .sec_grant(sec_grant), .sec_mwi(sec_mwi), .sec_master_stop(sec_master_stop),
  .primary_bus_num(primary_bus_num), .secondary_bus_num(secondary_bus_num),
  .subordinate_bus_num(subordinate_bus_num));

// ==== test/testbench.sv ====
// self-checking bench for the bus number and i/o window registers
// assumes the register block as top with its checker bound
`timescale 1ns/1ps
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, io_addr = 32'h0000_0000, rd;
  logic [3:0] pstrb = 4'h0;
  logic [15:0] io_base_upper = 16'h0001, io_limit_upper = 16'h0001;
  logic sec_frame_start = 0, sec_mastering = 0, sec_grant = 1, sec_data_phase_done = 0, sec_mwi = 0;
  logic pready, pslverr, io_forward, sec_latency_expired, sec_master_stop, err;
  logic [7:0] pri, sec, sub;
  logic [31:0] ads [5] = '{32'h0001_2000, 32'h0001_1fff, 32'h0001_3fff, 32'h0001_4000, 32'h0002_2000};
  logic exps [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  int bad_count = 0, num_checks = 0, n;
  bridge_bus_number_io_window_regs i_bridge_bus_number_io_window_regs (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .io_base_upper(io_base_upper),
    .io_limit_upper(io_limit_upper), .io_addr(io_addr), .io_forward(io_forward),
    .sec_frame_start(sec_frame_start), .sec_mastering(sec_mastering), .sec_grant(sec_grant),
    .sec_data_phase_done(sec_data_phase_done), .sec_mwi(sec_mwi), .sec_latency_expired(sec_latency_expired),
    .sec_master_stop(sec_master_stop), .primary_bus_num(pri), .secondary_bus_num(sec), .subordinate_bus_num(sub));
  initial begin
    forever #2 pclk = ~pclk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic xe);
    xfer(0, a, 32'h0000_0000, 4'h0);
    chk(name, exp, rd);
    chk({name, "_err"}, {31'h0, xe}, {31'h0, err});
  endtask
  task automatic step_chk(input string name, input logic exp);
    @(negedge pclk);
    chk(name, {31'h0, exp}, {31'h0, sec_master_stop});
    @(posedge pclk);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rdchk("rst_bus", 8'h18, 32'h0000_0000, 0);
    rdchk("rst_io", 8'h1c, 32'h0000_0101, 0);
    xfer(1, 8'h18, 32'ha5c3_3c5a, 4'hf);
    rdchk("bus", 8'h18, 32'ha5c3_3c5a, 0);
    chk("pins", 32'h00c3_3c5a, {8'h00, sub, sec, pri});
    xfer(1, 8'h18, 32'hffff_ffff, 4'b0010);
    rdchk("lane", 8'h18, 32'ha5c3_ff5a, 0);
    xfer(1, 8'h1c, 32'hffff_ffff, 4'hf);
    rdchk("io_ro", 8'h1c, 32'h0000_f1f1, 0);
    rdchk("unmapped", 8'h20, 32'h0000_0000, 1);
    xfer(1, 8'h1c, 32'h0000_3020, 4'b0011);
    for (n = 0; n < 5; n++) begin
      io_addr <= ads[n];
      @(negedge pclk);
      chk("window", {31'h0, exps[n]}, {31'h0, io_forward});
      @(posedge pclk);
    end
    xfer(1, 8'h18, 32'h0400_0000, 4'b1000);
    sec_frame_start <= 1;
    sec_mastering <= 1;
    @(posedge pclk);
    sec_frame_start <= 0;
    n = 0;
    @(negedge pclk);
    while (sec_latency_expired !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
      @(negedge pclk);
    end
    chk("lat_count", 32'h0000_0004, n);
    @(posedge pclk);
    sec_mastering <= 0;
    xfer(1, 8'h18, 32'h0000_0000, 4'b1000);
    sec_grant <= 0;
    sec_frame_start <= 1;
    sec_mastering <= 1;
    @(posedge pclk);
    sec_frame_start <= 0;
    sec_data_phase_done <= 1;
    step_chk("stop_early", 0);
    sec_data_phase_done <= 0;
    step_chk("stop", 1);
    sec_mwi <= 1;
    step_chk("stop_mwi", 0);
    sec_mwi <= 0;
    sec_grant <= 1;
    step_chk("stop_gnt", 0);
    sec_mastering <= 0;
    end_sim();
  end
endmodule
